// >>> src/otp_prog_regs.vh
// Timing, retry and identification constants for the OTP programming sequencer.
`ifndef OTP_PROG_REGS_VH
`define OTP_PROG_REGS_VH
`define CLK_MHZ            25
`define PULSE_US           100
`define PULSE_CYC          (`PULSE_US * `CLK_MHZ)
`define SETUP_US           2
`define SETUP_CYC          (`SETUP_US * `CLK_MHZ)
`define FLOAT_NS           130
`define FLOAT_CYC          ((`FLOAT_NS * `CLK_MHZ + 999) / 1000)
`define DV_US              1
`define DV_CYC             (`DV_US * `CLK_MHZ)
`define MAX_RETRY          10
`define ID_MFR_SEL         1'b0
`define ID_DEV_SEL         1'b1
`endif

// >>> src/otp_prom_program_sequencer.v
// Programming sequencer that drives a 64K x 8 OTP memory through its pins.
`timescale 1ns/10ps
`include "otp_prog_regs.vh"
// Contract
// R1: Program each byte with a low chip-enable pulse of 95 to 105 us.
// R2: Start each programming session at address zero.
// R3: Raise main supply to 6.5 V and program supply to 13.0 V first.
// R4: First pass gives every address one pulse without verifying.
// R5: Verify each address; on failure apply up to ten more pulses, verifying each.
// R6: A byte failing after ten pulses marks the device as failed.
// R7: Advance to the next address once a byte verifies, until all checked.
// R8: Then drop program supply low, main supply to 5.0 V, compare every byte.
// R9: Main supply up no later, and down no earlier, than program supply.
// R10: Allow output enable access and the 130 ns float delay after chip-enable.
// R11: Identification mode returns manufacturer code on select low, device code high.
// R12: Identification needs the mode address line at 11.5 to 12.5 V.
// R13: During identification all other address lines are held low.
// R14: Verify reads drive output enable low with chip-enable low.
module otp_prom_program_sequencer #(
    parameter AW        = 16,
    parameter PULSE_CYC = `PULSE_CYC
) (
    input  wire          i_clk,
    input  wire          i_rst,
    input  wire          i_ce,
    input  wire          i_start_prog,
    input  wire          i_start_id,
    input  wire [AW-1:0] i_last_addr,
    input  wire [7:0]    i_src_data,
    input  wire [7:0]    i_byte_outputs,
    output reg  [AW-1:0] o_addr,
    output reg  [7:0]    o_data,
    output reg           o_data_oe,
    output reg           o_chip_en_n,
    output reg           o_oe_n,
    output reg           o_vpp_en,
    output reg           o_vcc_prog,
    output reg           o_vcc_on,
    output reg           o_id_mode_address_line,
    output reg           o_id_code_select_line,
    output reg  [7:0]    o_mfr_code,
    output reg  [7:0]    o_dev_code,
    output reg           o_busy,
    output reg           o_done,
    output reg           o_fail
);
    // One-hot states; the verify loop re-enters the pulse states for each retry.
    localparam [10:0] S_IDLE  = 11'h001;
    localparam [10:0] S_PWRUP = 11'h002;
    localparam [10:0] S_VPPUP = 11'h004;
    localparam [10:0] S_PULSE = 11'h008;
    localparam [10:0] S_HOLD  = 11'h010;
    localparam [10:0] S_VREAD = 11'h020;
    localparam [10:0] S_VEND  = 11'h040;
    localparam [10:0] S_VDOWN = 11'h080;
    localparam [10:0] S_CMP   = 11'h100;
    localparam [10:0] S_ID    = 11'h200;
    localparam [10:0] S_FIN   = 11'h400;
    // Timing figures arrive as 32-bit integers; timer and retry fields are sliced on purpose.
    localparam integer PULSE_I = PULSE_CYC;
    localparam integer SETUP_I = `SETUP_CYC;
    localparam integer FLOAT_I = `FLOAT_CYC;
    localparam integer DV_I    = `DV_CYC;
    localparam integer RETRY_I = `MAX_RETRY;
    localparam [15:0]  T_PULSE = PULSE_I[15:0];
    localparam [15:0]  T_SETUP = SETUP_I[15:0];
    localparam [15:0]  T_FLOAT = FLOAT_I[15:0];
    localparam [15:0]  T_DV    = DV_I[15:0];
    localparam [3:0]   N_RETRY = RETRY_I[3:0];
    // A verify read waits for data valid plus the float of the previous drive.
    localparam [15:0]  T_READ  = T_DV + T_FLOAT;
    // Between a read and the next step the outputs must float and the supplies settle.
    localparam [15:0]  T_RECOV = T_SETUP + T_FLOAT;

    reg [10:0]   state_reg;
    reg [15:0]   tmr_reg;
    reg [3:0]    retry_reg;
    reg          pass2_reg;
    reg          idsel_reg;
    reg [7:0]    dsync1_reg;
    reg [7:0]    dsync2_reg;

    // Reading device outputs only after the data-valid wait also covers sync latency.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dsync1_reg <= 8'h00;
            dsync2_reg <= 8'h00;
        end else if (i_ce) begin
            dsync1_reg <= i_byte_outputs;
            dsync2_reg <= dsync1_reg;
        end
    end

    // One shared down-counter paces every step; a state loads it and waits for zero.
    wire tmr_done = (tmr_reg == 16'h0000);
    wire at_last  = (o_addr == i_last_addr);

    // Address stepping is shared by the first pass, the verify loop and the final compare.
    function [AW-1:0] addr_step;
        input [AW-1:0] addr;
        addr_step = addr + {{(AW-1){1'b0}}, 1'b1};
    endfunction

    // The whole sequence lives in one clocked process so that every pin is a flop.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg              <= S_IDLE;
            tmr_reg                <= 16'h0000;
            retry_reg              <= 4'h0;
            pass2_reg              <= 1'b0;
            idsel_reg              <= 1'b0;
            o_addr                 <= {AW{1'b0}};
            o_data                 <= 8'h00;
            o_data_oe              <= 1'b0;
            o_chip_en_n            <= 1'b1;
            o_oe_n                 <= 1'b1;
            o_vpp_en               <= 1'b0;
            o_vcc_prog             <= 1'b0;
            o_vcc_on               <= 1'b0;
            o_id_mode_address_line <= 1'b0;
            o_id_code_select_line  <= 1'b0;
            o_mfr_code             <= 8'h00;
            o_dev_code             <= 8'h00;
            o_busy                 <= 1'b0;
            o_done                 <= 1'b0;
            o_fail                 <= 1'b0;
        end else if (i_ce) begin
            // Holding the enable low mid-pulse stretches the pulse past its limit.
            if (!tmr_done)
                tmr_reg <= tmr_reg - 16'h0001;
            case (state_reg)
                // Starts are taken only here, so a request while busy is simply dropped.
                S_IDLE: begin
                    if (i_start_prog) begin
                        o_addr     <= {AW{1'b0}}; // R2
                        o_vcc_on   <= 1'b1; // R9
                        o_vcc_prog <= 1'b1; // R3
                        o_busy     <= 1'b1;
                        o_done     <= 1'b0;
                        o_fail     <= 1'b0;
                        pass2_reg  <= 1'b0;
                        tmr_reg    <= T_SETUP;
                        state_reg  <= S_PWRUP;
                    end else if (i_start_id) begin
                        o_addr                 <= {AW{1'b0}}; // R13
                        o_vcc_on               <= 1'b1;
                        o_id_mode_address_line <= 1'b1; // R12
                        o_id_code_select_line  <= `ID_MFR_SEL; // R11
                        // Identification reads need both enables low, with only the main supply raised.
                        o_oe_n                 <= 1'b0;
                        o_chip_en_n            <= 1'b0;
                        idsel_reg              <= 1'b0;
                        o_busy                 <= 1'b1;
                        o_done                 <= 1'b0;
                        tmr_reg                <= T_SETUP;
                        state_reg              <= S_ID;
                    end
                end

                // Main supply leads the programming supply by a full setup time.
                S_PWRUP: if (tmr_done) begin
                    o_vpp_en  <= 1'b1; // R9
                    tmr_reg   <= T_SETUP;
                    state_reg <= S_VPPUP;
                end

                // Address settles for the setup time; data is driven on the same edge that the pulse begins.
                S_VPPUP: if (tmr_done) begin
                    o_data      <= i_src_data;
                    o_data_oe   <= 1'b1;
                    o_chip_en_n <= 1'b0; // R1
                    tmr_reg     <= T_PULSE - 16'h0001;
                    state_reg   <= S_PULSE;
                end

                // The pulse is counted in whole clocks, so its width is only as good as the clock.
                S_PULSE: if (tmr_done) begin
                    o_chip_en_n <= 1'b1; // R1
                    tmr_reg     <= T_SETUP;
                    state_reg   <= S_HOLD;
                end

                // Data stays driven past the rising chip enable before the bus is let go.
                S_HOLD: if (tmr_done) begin
                    o_data_oe <= 1'b0;
                    if (!pass2_reg) begin
                        if (at_last) begin
                            pass2_reg <= 1'b1;
                            o_addr    <= {AW{1'b0}};
                            retry_reg <= 4'h0;
                            tmr_reg   <= T_SETUP;
                            state_reg <= S_VEND;
                        end else begin
                            // Next byte goes straight to a pulse; no verify here.
                            o_addr    <= addr_step(o_addr); // R4
                            tmr_reg   <= T_SETUP;
                            state_reg <= S_VPPUP;
                        end
                    end else begin
                        tmr_reg   <= T_SETUP;
                        state_reg <= S_VEND;
                    end
                end

                // The programming supply drops so the shared pin works as a plain output enable.
                S_VEND: if (tmr_done) begin
                    o_vpp_en    <= 1'b0;
                    o_oe_n      <= 1'b0; // R14
                    o_chip_en_n <= 1'b0; // R14
                    tmr_reg     <= T_READ; // R10
                    state_reg   <= S_VREAD;
                end

                // A byte still failing after the last allowed retry ends the session.
                S_VREAD: if (tmr_done) begin
                    o_chip_en_n <= 1'b1;
                    o_oe_n      <= 1'b1;
                    tmr_reg     <= T_RECOV; // R10
                    if (dsync2_reg == i_src_data) begin
                        retry_reg <= 4'h0;
                        if (at_last) begin
                            state_reg <= S_VDOWN;
                        end else begin
                            o_addr    <= addr_step(o_addr); // R7
                            o_vpp_en  <= 1'b1;
                            state_reg <= S_FIN;
                        end
                    end else if (retry_reg == N_RETRY) begin
                        o_fail    <= 1'b1; // R6
                        state_reg <= S_VDOWN;
                    end else begin
                        retry_reg <= retry_reg + 4'h1; // R5
                        o_vpp_en  <= 1'b1;
                        state_reg <= S_VPPUP;
                    end
                end

                S_FIN: if (tmr_done) begin
                    // Recovery after a passing byte before the next verify read.
                    o_vpp_en  <= 1'b0;
                    tmr_reg   <= T_SETUP;
                    state_reg <= S_VEND;
                end

                // A failed session skips the final compare and powers straight down.
                S_VDOWN: if (tmr_done) begin
                    o_vpp_en   <= 1'b0; // R8
                    o_vcc_prog <= 1'b0; // R8
                    o_addr     <= {AW{1'b0}};
                    tmr_reg    <= T_SETUP;
                    state_reg  <= o_fail ? S_IDLE : S_CMP;
                    o_busy     <= o_fail ? 1'b0 : 1'b1;
                    o_done     <= o_fail;
                    o_vcc_on   <= ~o_fail; // R9
                end

                // A mismatch in the final compare is kept, but the pass runs to the end.
                S_CMP: begin
                    o_oe_n      <= 1'b0;
                    o_chip_en_n <= 1'b0;
                    if (tmr_done) begin
                        if (dsync2_reg != i_src_data)
                            o_fail <= 1'b1; // R8
                        if (at_last) begin
                            o_chip_en_n <= 1'b1;
                            o_oe_n      <= 1'b1;
                            o_vcc_on    <= 1'b0;
                            o_busy      <= 1'b0;
                            o_done      <= 1'b1;
                            state_reg   <= S_IDLE;
                        end else begin
                            o_addr  <= addr_step(o_addr);
                            tmr_reg <= T_READ;
                        end
                    end
                end

                // Codes are captured one after the other, manufacturer select first.
                S_ID: if (tmr_done) begin
                    if (!idsel_reg) begin
                        o_mfr_code            <= dsync2_reg; // R11
                        o_id_code_select_line <= `ID_DEV_SEL;
                        idsel_reg             <= 1'b1;
                        tmr_reg               <= T_SETUP;
                    end else begin
                        o_dev_code             <= dsync2_reg; // R11
                        o_id_mode_address_line <= 1'b0;
                        o_id_code_select_line  <= 1'b0;
                        o_oe_n                 <= 1'b1;
                        o_chip_en_n            <= 1'b1;
                        o_vcc_on               <= 1'b0;
                        o_busy                 <= 1'b0;
                        o_done                 <= 1'b1;
                        state_reg              <= S_IDLE;
                    end
                end

                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule

// >>> tb/otp_device_model.sv
// Behavioural model of the one-time programmable memory facing the sequencer.
`timescale 1ns/10ps
module otp_device_model #(
    parameter [7:0] MFR_CODE = 8'h5c, // Arbitrary value.
    parameter [7:0] DEV_CODE = 8'ha3  // Arbitrary value.
) (
    input  wire        i_clk,
    input  wire [15:0] i_addr,
    input  wire [7:0]  i_data,
    input  wire        i_data_oe,
    input  wire        i_chip_en_n,
    input  wire        i_oe_n,
    input  wire        i_vpp_en,
    input  wire        i_id_mode_address_line,
    input  wire        i_id_code_select_line,
    input  wire        i_clear,
    input  wire [3:0]  i_weak_addr,
    input  wire [3:0]  i_weak_need,
    output wire [7:0]  o_byte_outputs,
    output integer     o_pulses
);
    reg [7:0] mem [0:15];
    reg [7:0] last = 8'h00;
    reg [7:0] pd;
    reg [3:0] pa;
    reg [3:0] hits;
    reg       pend;
    integer   k;
    wire       drive = !i_chip_en_n && !i_oe_n && !i_vpp_en;
    wire [7:0] val   = i_id_mode_address_line ? (i_id_code_select_line ? DEV_CODE : MFR_CODE)
                                              : mem[i_addr[3:0]];
    // A released bus shows the inverse of its last value so stale data never matches.
    assign o_byte_outputs = drive ? val : ~last;
    always @(posedge i_clear) begin
        for (k = 0; k < 16; k = k + 1) mem[k] = 8'hff;
        hits = 4'h0;
        o_pulses = 0;
        pend <= 1'b0;
    end
    always @(posedge i_clk) begin
        if (drive) last <= val;
        if (!i_chip_en_n && i_vpp_en && i_data_oe) begin
            pend <= 1'b1;
            pd <= i_data;
            pa <= i_addr[3:0];
        end else if (pend && i_chip_en_n) begin
            pend <= 1'b0;
            o_pulses = o_pulses + 1;
            if (pa == i_weak_addr) hits = hits + 4'h1;
            // A weak cell with a need of zero never takes its data.
            if (pa != i_weak_addr || (i_weak_need != 4'h0 && hits >= i_weak_need)) mem[pa] = pd;
        end
    end
endmodule

// >>> tb/otp_prog_checker.sv
// Concurrent checks on the pins of the OTP programming sequencer.
`timescale 1ns/10ps
module otp_prog_checker #(
    parameter AW        = 16,
    parameter PULSE_CYC = 2500
) (
    input wire          i_clk,
    input wire          i_rst,
    input wire [AW-1:0] o_addr,
    input wire [7:0]    o_data,
    input wire          o_data_oe,
    input wire          o_chip_en_n,
    input wire          o_oe_n,
    input wire          o_vpp_en,
    input wire          o_vcc_prog,
    input wire          o_vcc_on,
    input wire          o_id_mode_address_line,
    input wire          o_busy,
    input wire          o_done,
    input wire          o_fail
);
    reg [15:0]   lo_cnt;
    reg [3:0]    pcnt;
    reg [AW-1:0] addr_q;
    reg          ce_q;
    reg          vcc_q;
    reg          first_pend;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lo_cnt <= 16'h0000;
            pcnt <= 4'h0;
            addr_q <= {AW{1'b0}};
            ce_q <= 1'b1;
            vcc_q <= 1'b0;
            first_pend <= 1'b0;
        end else begin
            lo_cnt <= o_chip_en_n ? 16'h0000 : lo_cnt + 16'h0001;
            addr_q <= o_addr;
            ce_q <= o_chip_en_n;
            vcc_q <= o_vcc_prog;
            if (!o_busy || o_addr != addr_q) pcnt <= 4'h0;
            else if (ce_q && !o_chip_en_n && o_vpp_en) pcnt <= pcnt + 4'h1;
            if (o_vcc_prog && !vcc_q) first_pend <= 1'b1;
            else if (!o_chip_en_n && o_vpp_en) first_pend <= 1'b0;
        end
    end
    pulse_width_a: assert property ($rose(o_chip_en_n) && $past(o_vpp_en) |-> lo_cnt == PULSE_CYC)
        else $error("program pulse width wrong");
    first_addr_a: assert property ($fell(o_chip_en_n) && first_pend |-> o_addr == 0)
        else $error("session does not start at address zero");
    supply_order_a: assert property (o_vpp_en |-> o_vcc_on && o_vcc_prog)
        else $error("program supply without main supply");
    pulse_supply_a: assert property (!o_chip_en_n && o_data_oe |-> o_vpp_en)
        else $error("data driven without program supply");
    hold_stable_a: assert property (!o_chip_en_n && $past(!o_chip_en_n) && o_vpp_en
        |-> $stable(o_data) && $stable(o_addr))
        else $error("address or data moved in a pulse");
    retry_bound_a: assert property (pcnt <= 4'd10)
        else $error("too many pulses on one address");
    addr_step_a: assert property (o_busy && !o_id_mode_address_line && o_addr != $past(o_addr)
        |-> o_addr == $past(o_addr) + 1 || o_addr == 0)
        else $error("address skipped");
    verify_read_a: assert property (!o_chip_en_n && !o_vpp_en |-> !o_oe_n && !o_data_oe)
        else $error("read without output enable");
    end_supply_a: assert property ($rose(o_done) |-> !o_vpp_en && !o_vcc_prog)
        else $error("supplies not lowered at end");
    id_lines_a: assert property (o_id_mode_address_line |-> (o_addr >> 1) == 0 && !o_vpp_en)
        else $error("address lines not low in identification");
    cover property ($rose(o_fail));
    cover property ($rose(o_done) && !o_fail);
    cover property ($rose(o_id_mode_address_line));
endmodule
bind otp_prom_program_sequencer otp_prog_checker #(.AW(AW), .PULSE_CYC(PULSE_CYC))
    otp_prog_checker_inst (.i_clk(i_clk), .i_rst(i_rst), .o_addr(o_addr), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_chip_en_n(o_chip_en_n), .o_oe_n(o_oe_n), .o_vpp_en(o_vpp_en),
    .o_vcc_prog(o_vcc_prog), .o_vcc_on(o_vcc_on), .o_busy(o_busy), .o_done(o_done),
    .o_id_mode_address_line(o_id_mode_address_line), .o_fail(o_fail));

// >>> tb/tb_otp_prom_program_sequencer.sv
// Self-checking bench for the OTP programming sequencer.
`timescale 1ns/10ps
module tb_otp_prom_program_sequencer;
    reg         i_clk = 1'b0;
    reg         i_rst = 1'b1;
    reg         i_start_prog = 1'b0;
    reg         i_start_id = 1'b0;
    reg         i_ce = 1'b1;
    reg  [7:0]  i_src_data = 8'h00;
    reg         dev_clear = 1'b0;
    reg  [3:0]  weak_addr = 4'hf;
    reg  [3:0]  weak_need = 4'h1;
    wire [15:0] o_addr;
    wire [7:0]  o_data, o_byte_outputs, o_mfr_code, o_dev_code;
    wire        o_data_oe, o_chip_en_n, o_oe_n, o_vpp_en, o_vcc_prog, o_vcc_on;
    wire        o_id_mode_address_line, o_id_code_select_line, o_busy, o_done, o_fail;
    integer     pulses, fail_count = 0, tests_run = 0;
    always #20 i_clk = ~i_clk;
    function [7:0] src(input [15:0] a);
        src = {a[3:0], ~a[3:0]} ^ 8'h3c;
    endfunction
    always @(posedge i_clk) i_src_data <= src(o_addr);
    otp_prom_program_sequencer #(.AW(16), .PULSE_CYC(20)) otp_prom_program_sequencer_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_start_prog(i_start_prog),
        .i_start_id(i_start_id), .i_last_addr(16'h0003), .i_src_data(i_src_data),
        .i_byte_outputs(o_byte_outputs), .o_addr(o_addr), .o_data(o_data),
        .o_data_oe(o_data_oe), .o_chip_en_n(o_chip_en_n), .o_oe_n(o_oe_n), .o_vpp_en(o_vpp_en),
        .o_vcc_prog(o_vcc_prog), .o_vcc_on(o_vcc_on), .o_id_mode_address_line(o_id_mode_address_line),
        .o_id_code_select_line(o_id_code_select_line), .o_mfr_code(o_mfr_code),
        .o_dev_code(o_dev_code), .o_busy(o_busy), .o_done(o_done), .o_fail(o_fail));
    otp_device_model otp_device_model_inst (.i_clk(i_clk), .i_addr(o_addr), .i_data(o_data),
        .i_data_oe(o_data_oe), .i_chip_en_n(o_chip_en_n), .i_oe_n(o_oe_n), .i_vpp_en(o_vpp_en),
        .i_id_mode_address_line(o_id_mode_address_line), .i_clear(dev_clear),
        .i_id_code_select_line(o_id_code_select_line), .i_weak_addr(weak_addr),
        .i_weak_need(weak_need), .o_byte_outputs(o_byte_outputs), .o_pulses(pulses));
    task final_report;
        if (fail_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task run(input prog);
        integer n;
        n = 0;
        @(posedge i_clk) {i_start_prog, i_start_id} <= {prog, !prog};
        @(posedge i_clk) {i_start_prog, i_start_id} <= {!prog, 1'b0};
        @(posedge i_clk) i_start_prog <= 1'b0;
        while (o_done !== 1'b1 && n < 20000) begin
            @(posedge i_clk);
            n = n + 1;
        end
        if (n >= 20000) begin
            fail_count = fail_count + 1;
            $display("ERROR %0t: no completion", $time);
            final_report;
        end
    endtask
    // A start raised while the identification run is busy must be ignored.
    task id_case;
        run(1'b0);
        chk(o_mfr_code, 8'h5c);
        chk(o_dev_code, 8'ha3);
        chk(o_vcc_prog, 1'b0);
    endtask
    task prog_case(input [3:0] wa, input [3:0] need, input efail, input integer epulses);
        integer k;
        weak_addr = wa;
        weak_need = need;
        dev_clear = 1'b1;
        #1 dev_clear = 1'b0;
        run(1'b1);
        chk(o_fail, efail);
        chk(pulses, epulses);
        for (k = 0; k < 4 && !efail; k = k + 1) chk(otp_device_model_inst.mem[k], src(k));
    endtask
    task reset_case;
        @(posedge i_clk) i_start_prog <= 1'b1;
        repeat (300) @(posedge i_clk) i_start_prog <= 1'b0;
        i_rst <= 1'b1;
        @(posedge i_clk) i_rst <= 1'b0;
        chk({o_vpp_en, o_chip_en_n, o_oe_n, o_busy}, 4'b0110);
        // A start held while the clock enable is low must not open a session.
        i_ce <= 1'b0;
        i_start_prog <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_ce <= 1'b1;
        i_start_prog <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk({o_busy, o_vcc_on}, 2'b00);
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        prog_case(4'hf, 4'h1, 1'b0, 4);
        prog_case(4'h2, 4'h3, 1'b0, 6);
        prog_case(4'h1, 4'h0, 1'b1, 14);
        id_case;
        reset_case;
        prog_case(4'hf, 4'h1, 1'b0, 4);
        final_report;
    end
endmodule
